// [testbench/ime_core_model.sv]
// partner model: core accumulator and port D pin levels seen by the executor
`timescale 1ns/100ps
`default_nettype none
module ime_core_model (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire ime_pkg::ime_acc_wr_t i_acc_wr,
  input  wire logic                 i_acc_load,
  input  wire logic [3:0]           i_acc_val,
  input  wire logic [7:0]           i_portd_out,
  input  wire logic [7:0]           i_portd_oe,
  input  wire logic [7:0]           i_portd_ext,
  output var  logic [3:0]           o_acc,
  output var  logic [7:0]           o_portd_pin
);
  import ime_pkg::*;

  // the core writes A only when the executor asks; bench loads win for setup
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_acc <= 4'h0;
    end else if (i_acc_load) begin
      o_acc <= i_acc_val;
    end else if (i_acc_wr.en) begin
      o_acc <= i_acc_wr.data;
    end
  end

  // an undriven pin shows whatever the outside world puts on it
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      o_portd_pin[b] = i_portd_oe[b] ? i_portd_out[b] : i_portd_ext[b];
    end
  end
endmodule
`default_nettype wire

// [testbench/ime_exec_tb_top.sv]
// self-checking bench for the io and miscellaneous instruction executor
`timescale 1ns/100ps
`default_nettype none
module ime_exec_tb_top;
  import ime_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_rst     = 1'b1;
  ime_instr_t  instr     = '0;
  logic [2:0]  reg_y     = 3'h0;
  logic [2:0]  porte_in  = 3'h0;
  logic [3:0]  portg_in  = 4'h0;
  logic        power_flag = 1'b0;
  logic        wakeup    = 1'b0;
  logic        acc_load  = 1'b0;
  logic [3:0]  acc_val   = 4'h0;
  logic [7:0]  portd_ext = 8'h00;
  logic [3:0]  acc;
  logic [7:0]  portd_pin, o_portd_out, o_portd_oe;
  logic [1:0]  o_porte_out, o_logic_op_select;
  logic [3:0]  o_portg_out;
  logic [2:0]  o_pulldown_control;
  ime_acc_wr_t o_acc_wr;
  logic        o_skip, o_done, o_backup, o_sysclk, o_urs, o_wdclr;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  always #2 i_ref_clk = ~i_ref_clk;

  ime_exec uut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_instr(instr), .i_acc(acc),
    .i_reg_y(reg_y), .i_portd_in(portd_pin), .i_porte_in(porte_in), .i_portg_in(portg_in),
    .i_power_flag(power_flag), .i_wakeup(wakeup), .o_portd_out(o_portd_out),
    .o_portd_oe(o_portd_oe), .o_porte_out(o_porte_out), .o_portg_out(o_portg_out),
    .o_acc_wr(o_acc_wr), .o_skip(o_skip), .o_done(o_done), .o_backup(o_backup),
    .o_system_clock_source(o_sysclk), .o_logic_op_select(o_logic_op_select),
    .o_upper_rom_ref_flag(o_urs), .o_pulldown_control(o_pulldown_control),
    .o_watchdog_flag_one_clr(o_wdclr));

  ime_core_model u_core (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_acc_wr(o_acc_wr),
    .i_acc_load(acc_load), .i_acc_val(acc_val), .i_portd_out(o_portd_out),
    .i_portd_oe(o_portd_oe), .i_portd_ext(portd_ext), .o_acc(acc), .o_portd_pin(portd_pin));

  task automatic test_done();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one word, then look at done and skip right after the taking edge
  task automatic send(input logic [8:0] c, input logic [2:0] y, input logic ed, input logic es);
    @(posedge i_ref_clk);
    instr <= '{valid: 1'b1, code: c};
    reg_y <= y;
    @(posedge i_ref_clk);
    instr <= '0;
    #1;
    chk({6'h0, o_done, o_skip}, {6'h0, ed, es});
  endtask

  task automatic set_acc(input logic [3:0] v);
    @(posedge i_ref_clk);
    acc_load <= 1'b1;
    acc_val <= v;
    @(posedge i_ref_clk);
    acc_load <= 1'b0;
  endtask

  task automatic t_clock();
    chk(o_portd_oe, 8'h00);
    // first word after reset, so it stands at address zero of page zero
    send(OPC_CLOCK_CHANGE, 3'h0, 1'b1, 1'b0);
    chk({7'h0, o_sysclk}, 8'h01);
  endtask

  task automatic t_portd();
    for (int y = 0; y < 8; y++) begin
      send(OPC_SET_PORTD_BIT, y[2:0], 1'b1, 1'b0);
      chk(o_portd_out, 8'((16'h2 << y) - 16'h1));
    end
    send(OPC_CLEAR_PORTD_BIT, 3'h3, 1'b1, 1'b0);
    chk(o_portd_out, 8'hF7);
    // latch high drives pin high even though outside holds it low
    send(OPC_PORTD_ZSKIP_W1, 3'h7, 1'b0, 1'b0);
    send(OPC_PORTD_ZSKIP_W2, 3'h7, 1'b1, 1'b0);
    send(OPC_CLEAR_PORTD_BIT, 3'h7, 1'b1, 1'b0);
    send(OPC_PORTD_ZSKIP_W1, 3'h7, 1'b0, 1'b0);
    repeat (2) @(posedge i_ref_clk);
    send(OPC_PORTD_ZSKIP_W2, 3'h7, 1'b1, 1'b1);
    // a wrong second word ends the test unexecuted
    send(OPC_PORTD_ZSKIP_W1, 3'h7, 1'b0, 1'b0);
    send(OPC_SET_PORTD_BIT, 3'h3, 1'b0, 1'b0);
    chk(o_portd_out, 8'h77);
    send(OPC_CLEAR_ALL_PORTD, 3'h5, 1'b1, 1'b0);
    chk(o_portd_oe | o_portd_out, 8'h00);
    // undriven pin held high from outside: no skip; Y is taken with word 2
    @(posedge i_ref_clk);
    portd_ext <= 8'h80;
    send(OPC_PORTD_ZSKIP_W1, 3'h0, 1'b0, 1'b0);
    send(OPC_PORTD_ZSKIP_W2, 3'h7, 1'b1, 1'b0);
    send(9'h000, 3'h0, 1'b0, 1'b0);
  endtask

  task automatic t_ports();
    set_acc(4'hE);
    send(OPC_PORTE_OUTPUT, 3'h0, 1'b1, 1'b0);
    chk({6'h0, o_porte_out}, 8'h02);
    send(OPC_PORTG_OUTPUT, 3'h0, 1'b1, 1'b0);
    chk({4'h0, o_portg_out}, 8'h0E);
    @(posedge i_ref_clk);
    porte_in <= 3'h5;
    portg_in <= 4'hC;
    send(OPC_PORTE_INPUT, 3'h0, 1'b1, 1'b0);
    chk({3'h0, o_acc_wr}, 8'h15);
    send(OPC_PORTG_INPUT, 3'h0, 1'b1, 1'b0);
    chk({3'h0, o_acc_wr}, 8'h1C);
    @(posedge i_ref_clk);
    #1;
    chk({4'h0, acc}, 8'h0C);
  endtask

  task automatic t_misc();
    set_acc(4'hD);
    send(OPC_LOGIC_SEL_LOAD, 3'h0, 1'b1, 1'b0);
    chk({6'h0, o_logic_op_select}, 8'h01);
    send(OPC_PULLDOWN_LOAD, 3'h0, 1'b1, 1'b0);
    chk({5'h0, o_pulldown_control}, 8'h05);
    send(OPC_UPPER_ROM_SET, 3'h0, 1'b1, 1'b0);
    chk({7'h0, o_urs}, 8'h01);
    send(OPC_WATCHDOG_RST, 3'h0, 1'b1, 1'b0);
    chk({7'h0, o_wdclr}, 8'h01);
    @(posedge i_ref_clk);
    power_flag <= 1'b1;
    #1;
    chk({6'h0, o_done, o_wdclr}, 8'h00);
    send(OPC_POWER_FLAG_SKIP, 3'h0, 1'b1, 1'b1);
    @(posedge i_ref_clk);
    power_flag <= 1'b0;
    send(OPC_POWER_FLAG_SKIP, 3'h0, 1'b1, 1'b0);
    send(OPC_ENTER_BACKUP, 3'h0, 1'b1, 1'b0);
    repeat (3) @(posedge i_ref_clk);
    wakeup <= 1'b1;
    #1;
    chk({7'h0, o_backup}, 8'h01);
    @(posedge i_ref_clk);
    wakeup <= 1'b0;
    #1;
    chk({7'h0, o_backup}, 8'h00);
  endtask

  // whole run needs under a hundred cycles; the ceiling of 3000 leaves ample margin
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end

  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    t_clock();
    t_portd();
    t_ports();
    t_misc();
    test_done();
  end
endmodule
`default_nettype wire

// [verilog/ime_decode.sv]
// opcode decoder for the io/misc instruction group
`timescale 1ns/100ps
`default_nettype none
module ime_decode (
  input  wire ime_pkg::ime_instr_t i_instr,
  output var  ime_pkg::ime_op_t    o_op
);
  import ime_pkg::*;

  always_comb begin
    o_op = IME_OP_NONE;
    if (i_instr.valid) begin
      unique case (i_instr.code)
        OPC_CLEAR_ALL_PORTD: o_op = IME_OP_CLEAR_ALL_PORTD;
        OPC_CLEAR_PORTD_BIT: o_op = IME_OP_CLEAR_PORTD_BIT;
        OPC_SET_PORTD_BIT:   o_op = IME_OP_SET_PORTD_BIT;
        OPC_PORTD_ZSKIP_W1:  o_op = IME_OP_PORTD_ZERO_SKIP;
        OPC_PORTE_OUTPUT:    o_op = IME_OP_PORTE_OUTPUT;
        OPC_PORTE_INPUT:     o_op = IME_OP_PORTE_INPUT;
        OPC_PORTG_OUTPUT:    o_op = IME_OP_PORTG_OUTPUT;
        OPC_PORTG_INPUT:     o_op = IME_OP_PORTG_INPUT;
        OPC_ENTER_BACKUP:    o_op = IME_OP_ENTER_BACKUP;
        OPC_POWER_FLAG_SKIP: o_op = IME_OP_POWER_FLAG_SKIP;
        OPC_CLOCK_CHANGE:    o_op = IME_OP_CLOCK_CHANGE;
        OPC_LOGIC_SEL_LOAD:  o_op = IME_OP_LOGIC_SELECT_LOAD;
        OPC_UPPER_ROM_SET:   o_op = IME_OP_UPPER_ROM_REF_SET;
        OPC_PULLDOWN_LOAD:   o_op = IME_OP_PULLDOWN_LOAD;
        OPC_WATCHDOG_RST:    o_op = IME_OP_WATCHDOG_RESTART;
        // codes outside this group belong to other executors
        default:             o_op = IME_OP_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [verilog/ime_exec.sv]
// executor for the io and miscellaneous instructions of the 4-bit core
`timescale 1ns/100ps
`default_nettype none
module ime_exec (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  input  wire ime_pkg::ime_instr_t  i_instr,
  input  wire logic [3:0]           i_acc,
  input  wire logic [2:0]           i_reg_y,
  input  wire logic [7:0]           i_portd_in,
  input  wire logic [2:0]           i_porte_in,
  input  wire logic [3:0]           i_portg_in,
  input  wire logic                 i_power_flag,
  input  wire logic                 i_wakeup,
  output var  logic [7:0]           o_portd_out,
  output var  logic [7:0]           o_portd_oe,
  output var  logic [1:0]           o_porte_out,
  output var  logic [3:0]           o_portg_out,
  output var  ime_pkg::ime_acc_wr_t o_acc_wr,
  output var  logic                 o_skip,
  output var  logic                 o_done,
  output var  logic                 o_backup,
  output var  logic                 o_system_clock_source,
  output var  logic [1:0]           o_logic_op_select,
  output var  logic                 o_upper_rom_ref_flag,
  output var  logic [2:0]           o_pulldown_control,
  output var  logic                 o_watchdog_flag_one_clr
);
  import ime_pkg::*;

  ime_op_t    op;
  ime_state_t state_r;
  ime_state_t state_nxt;
  logic       take;
  logic       word2_ok;
  logic [7:0] portd_latch;

  ime_decode u_decode (
    .i_instr (i_instr),
    .o_op    (op)
  );

  // only decode new instructions while no two-word test is open
  assign take     = (state_r == IME_ST_IDLE) && (op != IME_OP_NONE);
  assign word2_ok = (state_r == IME_ST_ZSKIP_WORD2) && i_instr.valid
                    && (i_instr.code == OPC_PORTD_ZSKIP_W2);

  ime_portd u_portd (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_clr_all (take && op == IME_OP_CLEAR_ALL_PORTD),
    .i_clr_bit (take && op == IME_OP_CLEAR_PORTD_BIT),
    .i_set_bit (take && op == IME_OP_SET_PORTD_BIT),
    .i_sel     (i_reg_y),
    .o_latch   (portd_latch)
  );

  // a one latch drives the pin high, a zero leaves it high-impedance
  assign o_portd_out = portd_latch;
  assign o_portd_oe  = portd_latch;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IME_ST_IDLE: begin
        if (take && op == IME_OP_PORTD_ZERO_SKIP) begin
          state_nxt = IME_ST_ZSKIP_WORD2;
        end
      end
      IME_ST_ZSKIP_WORD2: begin
        // a stray word closes the test without a skip
        if (i_instr.valid) begin
          state_nxt = IME_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= IME_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_skip <= 1'b0;
    end else begin
      o_skip <= (word2_ok && !i_portd_in[i_reg_y])
                || (take && op == IME_OP_POWER_FLAG_SKIP && i_power_flag);
    end
  end

  // carry is never written here; no path to it exists
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_done <= 1'b0;
    end else begin
      o_done <= (take && op != IME_OP_PORTD_ZERO_SKIP) || word2_ok;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_porte_out <= RST_PORTE;
      o_portg_out <= RST_PORTG;
    end else if (take && op == IME_OP_PORTE_OUTPUT) begin
      o_porte_out <= i_acc[1:0];
    end else if (take && op == IME_OP_PORTG_OUTPUT) begin
      o_portg_out <= i_acc;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_acc_wr <= '0;
    end else if (take && op == IME_OP_PORTE_INPUT) begin
      // a3 is written as zero; port E has only three input bits
      o_acc_wr <= '{en: 1'b1, data: {1'b0, i_porte_in}};
    end else if (take && op == IME_OP_PORTG_INPUT) begin
      o_acc_wr <= '{en: 1'b1, data: i_portg_in};
    end else begin
      o_acc_wr <= '0;
    end
  end

  // held until wakeup logic outside releases it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_backup <= 1'b0;
    end else if (take && op == IME_OP_ENTER_BACKUP) begin
      o_backup <= 1'b1;
    end else if (i_wakeup) begin
      o_backup <= 1'b0;
    end
  end

  // one-way switch: only reset returns to the divided clock
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_system_clock_source <= 1'b0;
    end else if (take && op == IME_OP_CLOCK_CHANGE) begin
      o_system_clock_source <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_logic_op_select <= RST_LOGIC_SEL;
    end else if (take && op == IME_OP_LOGIC_SELECT_LOAD) begin
      o_logic_op_select <= i_acc[1:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_upper_rom_ref_flag <= 1'b0;
    end else if (take && op == IME_OP_UPPER_ROM_REF_SET) begin
      o_upper_rom_ref_flag <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pulldown_control <= RST_PULLDOWN;
    end else if (take && op == IME_OP_PULLDOWN_LOAD) begin
      o_pulldown_control <= i_acc[2:0];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_watchdog_flag_one_clr <= 1'b0;
    end else begin
      o_watchdog_flag_one_clr <= take && op == IME_OP_WATCHDOG_RESTART;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_clear_all;
    take && op == IME_OP_CLEAR_ALL_PORTD |=> o_portd_oe == 8'h00;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("port D not cleared");

  property p_clear_bit;
    take && op == IME_OP_CLEAR_PORTD_BIT |=> !o_portd_oe[$past(i_reg_y)];
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("port D bit not cleared");

  property p_set_bit;
    take && op == IME_OP_SET_PORTD_BIT |=> o_portd_out[$past(i_reg_y)] && o_done;
  endproperty
  a_set_bit: assert property (p_set_bit) else $error("port D bit not set");

  // the first word only opens the test; nothing is answered for it
  property p_zero_wait;
    take && op == IME_OP_PORTD_ZERO_SKIP
      |=> state_r == IME_ST_ZSKIP_WORD2 && !o_done && !o_skip;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("first test word answered");

  property p_zero_skip;
    word2_ok |=> o_done && o_skip == $past(!i_portd_in[i_reg_y]);
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("two-word test wrong");

  // a stray word in place of word 2 closes the test silently
  property p_zero_stray;
    state_r == IME_ST_ZSKIP_WORD2 && i_instr.valid && i_instr.code != OPC_PORTD_ZSKIP_W2
      |=> !o_done && !o_skip && state_r == IME_ST_IDLE;
  endproperty
  a_zero_stray: assert property (p_zero_stray) else $error("stray word executed");

  property p_porte_out;
    take && op == IME_OP_PORTE_OUTPUT |=> o_porte_out == $past(i_acc[1:0]);
  endproperty
  a_porte_out: assert property (p_porte_out) else $error("port E output wrong");

  property p_portg_out;
    take && op == IME_OP_PORTG_OUTPUT |=> o_portg_out == $past(i_acc);
  endproperty
  a_portg_out: assert property (p_portg_out) else $error("port G output wrong");

  // the write pulse may only stretch when another input word follows at once
  property p_porte_in;
    take && op == IME_OP_PORTE_INPUT
      |=> o_acc_wr.en && o_acc_wr.data == {1'b0, $past(i_porte_in)}
      ##1 (!o_acc_wr.en
           || $past(take && (op == IME_OP_PORTE_INPUT || op == IME_OP_PORTG_INPUT)));
  endproperty
  a_porte_in: assert property (p_porte_in) else $error("port E input wrong");

  property p_portg_in;
    take && op == IME_OP_PORTG_INPUT |=> o_acc_wr.en && o_acc_wr.data == $past(i_portg_in);
  endproperty
  a_portg_in: assert property (p_portg_in) else $error("port G input wrong");

  property p_power_skip;
    take && op == IME_OP_POWER_FLAG_SKIP |=> o_skip == $past(i_power_flag) && o_done;
  endproperty
  a_power_skip: assert property (p_power_skip) else $error("power flag skip wrong");

  property p_skip_done;
    o_skip |-> o_done;
  endproperty
  a_skip_done: assert property (p_skip_done) else $error("skip without completion");

  property p_backup;
    take && op == IME_OP_ENTER_BACKUP |=> o_backup && o_done;
  endproperty
  a_backup: assert property (p_backup) else $error("backup not entered");

  property p_clock_sticky;
    o_system_clock_source |=> o_system_clock_source [*3];
  endproperty
  a_clock_sticky: assert property (p_clock_sticky) else $error("clock fell back");

  property p_logic_sel;
    take && op == IME_OP_LOGIC_SELECT_LOAD |=> o_logic_op_select == $past(i_acc[1:0]);
  endproperty
  a_logic_sel: assert property (p_logic_sel) else $error("logic select wrong");

  property p_upper_rom;
    take && op == IME_OP_UPPER_ROM_REF_SET |=> o_upper_rom_ref_flag;
  endproperty
  a_upper_rom: assert property (p_upper_rom) else $error("upper rom flag not set");

  property p_pulldown;
    take && op == IME_OP_PULLDOWN_LOAD |=> o_pulldown_control == $past(i_acc[2:0]);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down control wrong");

  // back-to-back restarts legally keep the clear high for a second cycle
  property p_watchdog;
    take && op == IME_OP_WATCHDOG_RESTART
      |=> o_watchdog_flag_one_clr
      ##1 (!o_watchdog_flag_one_clr || $past(take && op == IME_OP_WATCHDOG_RESTART));
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog clear not a pulse");

  property p_single_cycle;
    take && op != IME_OP_PORTD_ZERO_SKIP |=> o_done && state_r == IME_ST_IDLE;
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("one-cycle op late");

  c_zero_skip: cover property (word2_ok && !i_portd_in[i_reg_y] ##1 o_skip);
  c_power_skip: cover property (take && op == IME_OP_POWER_FLAG_SKIP ##1 o_skip);
  c_backup: cover property (take && op == IME_OP_ENTER_BACKUP ##1 o_backup);
  c_zero_stray: cover property (state_r == IME_ST_ZSKIP_WORD2 && i_instr.valid
                                && i_instr.code != OPC_PORTD_ZSKIP_W2);
endmodule
`default_nettype wire

// [verilog/ime_pkg.sv]
// shared constants, opcodes and carrier types for the io/misc instruction block
package ime_pkg;

  localparam int OPC_W = 9;

  // one-word opcodes
  localparam logic [8:0] OPC_CLEAR_ALL_PORTD = 9'h011;
  localparam logic [8:0] OPC_CLEAR_PORTD_BIT = 9'h014;
  localparam logic [8:0] OPC_SET_PORTD_BIT   = 9'h015;
  localparam logic [8:0] OPC_PORTE_OUTPUT    = 9'h084;
  localparam logic [8:0] OPC_PORTE_INPUT     = 9'h056;
  localparam logic [8:0] OPC_PORTG_OUTPUT    = 9'h080;
  localparam logic [8:0] OPC_PORTG_INPUT     = 9'h028;
  localparam logic [8:0] OPC_ENTER_BACKUP    = 9'h00D;
  localparam logic [8:0] OPC_POWER_FLAG_SKIP = 9'h003;
  localparam logic [8:0] OPC_CLOCK_CHANGE    = 9'h059;
  localparam logic [8:0] OPC_LOGIC_SEL_LOAD  = 9'h058;
  localparam logic [8:0] OPC_UPPER_ROM_SET   = 9'h082;
  localparam logic [8:0] OPC_PULLDOWN_LOAD   = 9'h08F;
  localparam logic [8:0] OPC_WATCHDOG_RST    = 9'h00F;
  // two-word port D zero test
  localparam logic [8:0] OPC_PORTD_ZSKIP_W1  = 9'h024;
  localparam logic [8:0] OPC_PORTD_ZSKIP_W2  = 9'h02B;

  // values after reset
  localparam logic [7:0] RST_PORTD      = 8'h00;
  localparam logic [1:0] RST_PORTE      = 2'h0;
  localparam logic [3:0] RST_PORTG      = 4'h0;
  localparam logic [1:0] RST_LOGIC_SEL  = 2'h0;
  localparam logic [2:0] RST_PULLDOWN   = 3'h0;

  typedef enum logic [3:0] {
    IME_OP_NONE,
    IME_OP_CLEAR_ALL_PORTD,
    IME_OP_CLEAR_PORTD_BIT,
    IME_OP_SET_PORTD_BIT,
    IME_OP_PORTD_ZERO_SKIP,
    IME_OP_PORTE_OUTPUT,
    IME_OP_PORTE_INPUT,
    IME_OP_PORTG_OUTPUT,
    IME_OP_PORTG_INPUT,
    IME_OP_ENTER_BACKUP,
    IME_OP_POWER_FLAG_SKIP,
    IME_OP_CLOCK_CHANGE,
    IME_OP_LOGIC_SELECT_LOAD,
    IME_OP_UPPER_ROM_REF_SET,
    IME_OP_PULLDOWN_LOAD,
    IME_OP_WATCHDOG_RESTART
  } ime_op_t;

  typedef enum logic {
    IME_ST_IDLE,
    IME_ST_ZSKIP_WORD2
  } ime_state_t;

  typedef struct packed {
    logic             valid;
    logic [OPC_W-1:0] code;
  } ime_instr_t;

  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } ime_acc_wr_t;

endpackage

// [verilog/ime_portd.sv]
// port D output latches, one flop per bit, addressed by register Y
`timescale 1ns/100ps
`default_nettype none
module ime_portd (
  input  wire  logic       i_ref_clk,
  input  wire  logic       i_rst,
  input  wire  logic       i_clr_all,
  input  wire  logic       i_clr_bit,
  input  wire  logic       i_set_bit,
  input  wire  logic [2:0] i_sel,
  output var   logic [7:0] o_latch
);
  import ime_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          o_latch[g] <= RST_PORTD[g];
        end else if (i_clr_all) begin
          o_latch[g] <= 1'b0;
        end else if (i_sel == 3'(g)) begin
          if (i_clr_bit) begin
            o_latch[g] <= 1'b0;
          end else if (i_set_bit) begin
            o_latch[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
